/* File: logic/sspsq_cfg.svh */
`ifndef SSPSQ_CFG_SVH
`define SSPSQ_CFG_SVH

// register byte offsets
`define SSPSQ_CTRL_OFS   8'h00
`define SSPSQ_PEND_OFS   8'h04
`define SSPSQ_STAT_OFS   8'h08

// converter_control_register field positions
`define SSPSQ_DUAL_BIT   0
`define SSPSQ_ASYNC_BIT  4
`define SSPSQ_SEQ_BIT    5
`define SSPSQ_ORDER_BIT  6
`define SSPSQ_EARLY_BIT  7
`define SSPSQ_CTRL_RST   32'h0000_0000
`define SSPSQ_CTRL_MASK  32'h0000_00f1

// status register field positions
`define SSPSQ_STAT_BUSY  0
`define SSPSQ_STAT_ST_LO 1
`define SSPSQ_STAT_PR_LO 4

// timing in converter clock periods
`define SSPSQ_SAMP_CYC   4'h2
`define SSPSQ_CONV_CYC   4'he

`endif

/* File: logic/sspsq_core.sv */
`include "sspsq_cfg.svh"

module sspsq_core
  import sspsq_pkg::*;
#(
  parameter int NPAIR = 13,
  parameter int NDED  = 4
) (
  input  wire logic             core_clk,          // converter clock
  input  wire logic             sys_rst,           // sync reset
  input  wire logic [7:0]       reg_addr,          // register byte address
  input  wire logic [31:0]      reg_wdata,         // write data
  input  wire logic             reg_wr,            // write strobe
  input  wire logic             reg_rd,            // read strobe
  output logic      [31:0]      reg_rdata,         // read data, next cycle
  input  wire logic [NPAIR-1:0] pair_req,          // pair requests, processor domain
  output logic      [NPAIR-1:0] pair_pending_flag, // per-pair pending
  output logic      [NDED-1:0]  dedicated_hold,    // 1 = dedicated hold holding
  output logic                  shared_sampling,   // shared hold sampling
  output logic      [4:0]       shared_channel,    // input on shared hold
  output logic                  conv_busy,         // conversion in progress
  output logic      [4:0]       conv_channel,      // input being converted
  output logic                  conv_done,         // pulse, one input finished
  output logic      [NPAIR-1:0] pair_irq           // pulse, pair interrupt
);

  localparam logic [3:0] NDED_L = 4'(NDED);

  if (NPAIR < 1 || NPAIR > 16) begin : g_bad_npair
    $error("sspsq_core: NPAIR must be 1..16");
  end
  if (NDED < 1 || NDED > NPAIR || NDED > 15) begin : g_bad_nded
    $error("sspsq_core: NDED must be 1..min(NPAIR,15)");
  end
  if (`SSPSQ_SAMP_CYC == 4'h0 || `SSPSQ_CONV_CYC == 4'h0) begin : g_bad_cyc
    $error("sspsq_core: phase lengths must be nonzero");
  end

  // lowest set index wins
  function automatic logic [3:0] top_pending(input logic [NPAIR-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NPAIR - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : top_pending

  // sampling phase before the first conversion
  function automatic logic need_samp1(input logic ded, input logic async_m,
                                      input logic seq_m, input logic odd_f);
    return ~ded | ~async_m | ~seq_m | odd_f;
  endfunction : need_samp1

  // sampling phase before the second conversion
  function automatic logic need_samp2(input logic ded, input logic seq_m,
                                      input logic odd_f);
    return (~odd_f & seq_m) | (odd_f & ~ded);
  endfunction : need_samp2

  // control register and decode
  logic [31:0]      ctrl_r;
  logic [31:0]      rdata_r;
  sspsq_state_t     state_r;
  sspsq_state_t     state_nxt;
  logic [3:0]       cnt_r;
  logic [3:0]       cnt_nxt;
  logic [3:0]       pair_r;
  logic             async_r;
  logic             seq_r;
  logic             oddf_r;
  logic             ded_r;
  logic [NPAIR-1:0] pend_r;
  logic [NDED-1:0]  held_r;
  logic [4:0]       conv_ch_r;
  logic             done_r;
  logic [NPAIR-1:0] irq_r;
  logic [NPAIR-1:0] req_rise;

  wire wr_ctrl = reg_wr && (reg_addr == `SSPSQ_CTRL_OFS);
  wire rd_ctrl = reg_rd && (reg_addr == `SSPSQ_CTRL_OFS);
  wire rd_pend = reg_rd && (reg_addr == `SSPSQ_PEND_OFS);
  wire rd_stat = reg_rd && (reg_addr == `SSPSQ_STAT_OFS);

  wire c_dual  = ctrl_r[`SSPSQ_DUAL_BIT];
  wire c_async = ctrl_r[`SSPSQ_ASYNC_BIT];
  wire c_seq   = ctrl_r[`SSPSQ_SEQ_BIT];
  wire c_order = ctrl_r[`SSPSQ_ORDER_BIT];
  wire c_early = ctrl_r[`SSPSQ_EARLY_BIT];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r <= `SSPSQ_CTRL_RST;
    end else if (wr_ctrl) begin
      // bits outside the mask read back as zero
      ctrl_r <= reg_wdata & `SSPSQ_CTRL_MASK;
    end
  end

  // status word: busy, state and pair in service
  logic [31:0] stat_word;
  always_comb begin
    stat_word                         = 32'h0000_0000;
    stat_word[`SSPSQ_STAT_BUSY]       = conv_busy;
    stat_word[`SSPSQ_STAT_ST_LO +: 3] = state_r;
    stat_word[`SSPSQ_STAT_PR_LO +: 4] = pair_r;
  end

  // unmapped reads return zero
  wire [31:0] rd_mux =
    rd_ctrl ? ctrl_r :
    rd_pend ? {{(32 - NPAIR){1'b0}}, pend_r} :
    rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata = rdata_r;

  // request resynchronisation
  sspsq_req_sync #(
    .W (NPAIR)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .req_in   (pair_req),
    .req_rise (req_rise)
  );

  // selection of the next pair
  wire [NPAIR-1:0] cand      = pend_r | req_rise;
  wire             cand_any  = |cand;
  wire [3:0]       sel_pair  = top_pending(cand);
  wire             sel_ded   = sel_pair < NDED_L;
  wire             sel_seq   = sel_ded ? (~c_dual & c_seq) : 1'b1;
  wire             sel_oddf  = ~c_dual & c_order;
  wire             sel_async = sel_ded & c_async;
  wire             sel_s1    = need_samp1(sel_ded, sel_async, sel_seq, sel_oddf);

  // phase counter runs down to zero
  wire cnt_end   = (cnt_r == 4'h0);
  wire conv1_end = (state_r == SSPSQ_CONV1) && cnt_end;
  wire conv2_end = (state_r == SSPSQ_CONV2) && cnt_end;
  wire s2_needed = need_samp2(ded_r, seq_r, oddf_r);

  // even input finished converting
  wire even_end  = (conv1_end && !oddf_r) || (conv2_end && oddf_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_end ? 4'h0 : cnt_r - 4'h1;
    case (state_r)
      SSPSQ_IDLE: begin
        cnt_nxt = 4'h0;
        if (cand_any) begin
          if (sel_s1) begin
            state_nxt = SSPSQ_SAMP1;
            cnt_nxt   = `SSPSQ_SAMP_CYC - 4'h1;
          end else begin
            state_nxt = SSPSQ_CONV1;
            cnt_nxt   = `SSPSQ_CONV_CYC - 4'h1;
          end
        end
      end
      SSPSQ_SAMP1: begin
        if (cnt_end) begin
          state_nxt = SSPSQ_CONV1;
          cnt_nxt   = `SSPSQ_CONV_CYC - 4'h1;
        end
      end
      SSPSQ_CONV1: begin
        if (cnt_end) begin
          if (s2_needed) begin
            state_nxt = SSPSQ_SAMP2;
            cnt_nxt   = `SSPSQ_SAMP_CYC - 4'h1;
          end else begin
            state_nxt = SSPSQ_CONV2;
            cnt_nxt   = `SSPSQ_CONV_CYC - 4'h1;
          end
        end
      end
      SSPSQ_SAMP2: begin
        if (cnt_end) begin
          state_nxt = SSPSQ_CONV2;
          cnt_nxt   = `SSPSQ_CONV_CYC - 4'h1;
        end
      end
      SSPSQ_CONV2: begin
        if (cnt_end) begin
          state_nxt = SSPSQ_IDLE;
        end
      end
      default: begin
        state_nxt = SSPSQ_IDLE;
        cnt_nxt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= SSPSQ_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // per-pair settings frozen for the pair in service
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pair_r  <= 4'h0;
      async_r <= 1'b0;
      seq_r   <= 1'b0;
      oddf_r  <= 1'b0;
      ded_r   <= 1'b0;
    end else if (state_r == SSPSQ_IDLE && cand_any) begin
      pair_r  <= sel_pair;
      async_r <= sel_async;
      seq_r   <= sel_seq;
      oddf_r  <= sel_oddf;
      ded_r   <= sel_ded;
    end
  end

  // pending flags: a new trigger wins over completion
  wire [NPAIR-1:0] pend_clr = conv2_end ? (NPAIR'(1) << pair_r) : '0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | req_rise;
    end
  end

  assign pair_pending_flag = pend_r;

  // dedicated hold state for asynchronous sampling
  wire [NDED-1:0] ded_clr = (even_end && ded_r) ? (NDED'(1) << pair_r) : '0;
  wire [NDED-1:0] raw_req = pair_req[NDED-1:0];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      held_r <= '0;
    end else if (c_async) begin
      // a new request wins over the clear
      held_r <= (held_r & ~ded_clr) | raw_req;
    end else begin
      held_r <= '0;
    end
  end

  wire samp1 = (state_r == SSPSQ_SAMP1);
  wire samp2 = (state_r == SSPSQ_SAMP2);

  // sync mode: dedicated samples only in the first phase of its pair
  genvar gi;
  for (gi = 0; gi < NDED; gi++) begin : g_ded
    wire mine   = ded_r && (pair_r == 4'(gi));
    wire sync_s = samp1 && mine && !async_r;
    // async: raw request stops sampling in the same cycle
    wire async_s = !(held_r[gi] || raw_req[gi]);
    assign dedicated_hold[gi] = c_async ? !async_s : !sync_s;
  end

  // shared hold: odd with the even input, or just before its conversion
  wire sh_s1 = samp1 && (!ded_r || oddf_r || !seq_r);
  assign shared_sampling = sh_s1 || samp2;

  // shared-only pairs sample each input before it converts
  wire sh_odd = ded_r ? 1'b1 : (samp1 ? oddf_r : !oddf_r);
  assign shared_channel = {pair_r, sh_odd};

  // conversion channel and done pulse
  wire conv_start1 = state_nxt == SSPSQ_CONV1 && state_r != SSPSQ_CONV1;
  wire conv_start2 = state_nxt == SSPSQ_CONV2 && state_r != SSPSQ_CONV2;
  wire [3:0] np = (state_r == SSPSQ_IDLE) ? sel_pair : pair_r;
  wire       nodd1 = (state_r == SSPSQ_IDLE) ? sel_oddf : oddf_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conv_ch_r <= 5'h00;
    end else if (conv_start1) begin
      conv_ch_r <= {np, nodd1};
    end else if (conv_start2) begin
      conv_ch_r <= {pair_r, !oddf_r};
    end
  end

  assign conv_busy    = (state_r == SSPSQ_CONV1) || (state_r == SSPSQ_CONV2);
  assign conv_channel = conv_ch_r;

  // interrupt after first or second conversion
  wire irq_fire = c_early ? conv1_end : conv2_end;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      irq_r  <= '0;
    end else begin
      done_r <= conv1_end || conv2_end;
      irq_r  <= irq_fire ? (NPAIR'(1) << pair_r) : '0;
    end
  end

  assign conv_done = done_r;
  assign pair_irq  = irq_r;


endmodule : sspsq_core

/* File: logic/sspsq_pkg.sv */
package sspsq_pkg;

  typedef enum logic [2:0] {
    SSPSQ_IDLE  = 3'b000,
    SSPSQ_SAMP1 = 3'b001,
    SSPSQ_CONV1 = 3'b010,
    SSPSQ_SAMP2 = 3'b011,
    SSPSQ_CONV2 = 3'b100
  } sspsq_state_t;

endpackage : sspsq_pkg

/* File: logic/sspsq_req_sync.sv */
module sspsq_req_sync #(
  parameter int W = 13
) (
  input  wire logic         core_clk,  // converter clock
  input  wire logic         sys_rst,   // sync reset
  input  wire logic [W-1:0] req_in,    // raw requests, processor domain
  output logic      [W-1:0] req_rise   // one pulse per request
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= req_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign req_rise = sync_r & ~last_r;

endmodule : sspsq_req_sync

/* File: sim/sspsq_afe_model.sv */
module sspsq_afe_model (
  input  wire logic       core_clk,        // clock
  input  wire logic       clr,             // restart log
  input  wire logic       shared_sampling, // shared hold tracks
  input  wire logic       conv_busy,       // core converting
  input  wire logic [4:0] conv_channel,    // input converted
  output logic      [4:0] first_ch,        // first input converted
  output logic      [7:0] samp_cyc         // shared tracking time
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy_q;
  logic [4:0] ch_q;
  logic [3:0] n_r;
  wire        start = conv_busy && (!busy_q || conv_channel != ch_q);
  always_ff @(posedge core_clk) begin
    busy_q <= conv_busy;
    ch_q   <= conv_channel;
    if (clr) begin
      n_r      <= 4'h0;
      samp_cyc <= 8'h00;
    end else begin
      if (shared_sampling) samp_cyc <= samp_cyc + 8'h01;
      if (start) n_r <= n_r + 4'h1;
      if (start && n_r == 4'h0) first_ch <= conv_channel;
    end
  end
endmodule : sspsq_afe_model

/* File: sim/sspsq_core_assertions.sv */
module sspsq_chk #(
  parameter int NPAIR = 13,
  parameter int NDED  = 4
) (
  input wire logic             core_clk,          // clock
  input wire logic             sys_rst,           // reset
  input wire logic [7:0]       reg_addr,          // address
  input wire logic             reg_rd,            // read strobe
  input wire logic [31:0]      reg_rdata,         // read data
  input wire logic [NPAIR-1:0] pair_req,          // requests
  input wire logic [NPAIR-1:0] pair_pending_flag, // pending
  input wire logic [NDED-1:0]  dedicated_hold,    // holds
  input wire logic             shared_sampling,   // shared sampling
  input wire logic             conv_busy,         // converting
  input wire logic [4:0]       conv_channel,      // input converted
  input wire logic             conv_done,         // conversion end
  input wire logic [NPAIR-1:0] pair_irq           // pair interrupt
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  // busy cycles since the last conversion end
  assign cnt_nxt = conv_done ? {4'h0, conv_busy} : cnt_r + {4'h0, conv_busy};
  always_ff @(posedge core_clk) begin
    cnt_r <= sys_rst ? 5'h00 : cnt_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_conv;
    conv_done |-> cnt_r == 5'h0e;
  endproperty
  property p_samp;
    $rose(shared_sampling) |=> shared_sampling ##1 !shared_sampling;
  endproperty
  property p_s2c;
    $fell(shared_sampling) |-> conv_busy;
  endproperty
  property p_start;
    $rose(pair_req[0]) && pair_pending_flag == '0 && !conv_busy && !shared_sampling
      |-> ##[1:4] (shared_sampling || conv_busy || !dedicated_hold[0]);
  endproperty
  property p_rd;
    reg_rd && reg_addr == 8'h04 |=>
      reg_rdata == {{(32-NPAIR){1'b0}}, $past(pair_pending_flag)};
  endproperty
  property p_fall;
    |($past(pair_pending_flag) & ~pair_pending_flag) |-> conv_done;
  endproperty
  property p_irq;
    |pair_irq |-> |(pair_irq & $past(pair_pending_flag));
  endproperty
  property p_hold;
    conv_busy && conv_channel[4:3] == 2'b00 && !conv_channel[0]
      |-> dedicated_hold[conv_channel[2:1]];
  endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
  a_samp: assert property (p_samp) else $error("sampling length wrong");
  a_s2c: assert property (p_s2c) else $error("no conversion after sampling");
  a_start: assert property (p_start) else $error("idle request not started");
  a_rd: assert property (p_rd) else $error("pending readback wrong");
  a_fall: assert property (p_fall) else $error("pending cleared early");
  a_irq: assert property (p_irq) else $error("interrupt without pending");
  a_hold: assert property (p_hold) else $error("dedicated hold released");
  c_samp: cover property ($rose(shared_sampling));
  c_irq: cover property (pair_irq[1]);
  c_pair: cover property (conv_done ##14 conv_done);
endmodule : sspsq_chk

bind sspsq_core sspsq_chk #(.NPAIR(NPAIR), .NDED(NDED)) u_chk (
  .core_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .pair_req, .pair_pending_flag,
  .dedicated_hold, .shared_sampling, .conv_busy, .conv_channel, .conv_done, .pair_irq
);

/* File: sim/tb_single_sar_pair_sequencer.sv */
module tb_single_sar_pair_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, sys_rst, reg_wr, reg_rd, clr, ssamp, busy, done;
  logic [7:0]  reg_addr, cv, samp_cyc;
  logic [31:0] reg_wdata, reg_rdata;
  logic [12:0] pair_req, pend, irq;
  logic [12:0] seen [4];
  logic [12:0] exp_ord [4] = '{13'h0002, 13'h0001, 13'h0004, 13'h0080};
  logic [3:0]  dhold;
  logic [4:0]  cch, first_ch, shch;
  int          num_errors, checked, cyc, n;

  sspsq_core u_sspsq_core (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pair_req, .pair_pending_flag(pend), .dedicated_hold(dhold),
    .shared_sampling(ssamp), .shared_channel(shch), .conv_busy(busy), .conv_channel(cch),
    .conv_done(done), .pair_irq(irq));
  sspsq_afe_model u_sspsq_afe_model (.core_clk, .clr, .shared_sampling(ssamp),
    .conv_busy(busy), .conv_channel(cch), .first_ch, .samp_cyc);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // one pair through a full sample and conversion sequence
  task automatic run(input int p, input logic [7:0] c);
    logic [31:0] dn;
    logic [31:0] idone;
    logic        ord;
    logic [4:0]  sh_last;
    dn = 32'h0;
    idone = 32'h0;
    ord = c[6] & !c[0];
    sh_last = 5'h1f;
    wr(8'h00, {24'h0, c});
    @(posedge core_clk);
    #1 chk(dhold[0], !c[4]);
    @(posedge core_clk);
    clr         <= 1'b1;
    pair_req[p] <= 1'b1;
    #1 chk(dhold[0], (p == 0) || !c[4]);
    @(posedge core_clk);
    clr <= 1'b0;
    @(posedge core_clk);
    pair_req[p] <= 1'b0;
    repeat (45) begin
      @(posedge core_clk);
      #1;
      dn += done;
      if (irq[p] === 1'b1) idone = dn;
      if (ssamp === 1'b1) sh_last = shch;
    end
    chk(idone, c[7] ? 1 : 2);
    chk(first_ch, {p[3:0], ord});
    chk(samp_cyc, (p > 3) ? 4 : 2);
    chk(sh_last, {p[3:0], ((p > 3) ? !ord : 1'b1)});
    rd(8'h04, 32'h0);
  endtask : run

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {reg_wr, reg_rd, clr, reg_addr, reg_wdata, pair_req} = '0;
    sys_rst = 1'b1;
    seen = '{default: '0};
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(8'h00, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_00f1);
    rd(8'h0c, 32'h0);
    for (int k = 0; k < 17; k++) begin
      cv = (k < 16) ? 8'(k << 4) : 8'h61;
      run(0, cv);
      run(5, cv);
    end
    wr(8'h00, 32'h0);
    @(posedge core_clk);
    pair_req <= 13'h0086;
    repeat (2) @(posedge core_clk);
    pair_req <= 13'h0000;
    repeat (12) @(posedge core_clk);
    pair_req <= 13'h0001;
    repeat (2) @(posedge core_clk);
    pair_req <= 13'h0000;
    rd(8'h04, 32'h0000_0087);
    rd(8'h08, 32'h0000_0019);
    n = 0;
    repeat (160) begin
      @(posedge core_clk);
      #1;
      if (|irq && n < 4) begin
        seen[n] = irq;
        n++;
      end
    end
    for (int k = 0; k < 4; k++) chk(seen[k], exp_ord[k]);
    tally_and_finish();
  end
endmodule : tb_single_sar_pair_sequencer
